// file: hw/temp_host_word.sv
// What this block does
// - Period codes 5..100 kept, others become 40
// - No period given means four seconds
// - Bit 17 picks thermocouple or resistance variant
// - Bit 18 picks sensor curve per variant
// - Bit 24 picks two or four channels
// - Bit 25 picks automatic or manual four-channel
// - First commit after reset captures; later ignored
// - Manual read request answered by ready bit
// - Bit 26 picks channel pair in manual
// - Bit 13 switches low field to fault flags
// - Bit 14 marks valid channel one data
// - Bit 15 marks valid channel three data
// - Temperature is 13-bit binary, tenths of degree
// - Resistance variant uses two's complement sign
// - Fault bits 0-4: range, open, cold junction
// - Fault bit 5 internal, bit 6 wrong module
// - Upper half mirrors lower for channels two, four
// - Two-channel mode refreshes channels one, two, 0.3 s
`include "temp_consts.svh"
`default_nettype none
module temp_host_word
  import temp_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RESET_I,
  // Command word from the ladder controller
  input  wire logic [31:0] CMD_I,
  // Installed variant strap, 1 = resistance
  input  wire logic        VARIANT_I,
  // Converter results and faults
  input  wire logic        CONV_DONE_I,
  input  wire logic [12:0] CONV_LO_I,
  input  wire logic [12:0] CONV_HI_I,
  input  wire logic [3:0]  RANGE_FLT_I,
  input  wire logic [3:0]  OPEN_FLT_I,
  input  wire logic        CJ_FLT_I,
  input  wire logic        SYS_FLT_I,
  // Converter control
  output logic             CONV_START_O,
  output logic             CONV_PAIR_O,
  output logic             CONV_CURVE_O,
  output logic             CONV_RES_TYPE_O,
  // Result word to the ladder controller
  output logic [31:0]      RESULT_O
);
  localparam int TW = $clog2(TICK_CYCLES);

  logic [31:0]   cmd_meta_q;
  logic [31:0]   cmd_q;
  logic          var_meta_q;
  logic          var_q;
  logic [TW-1:0] div_q;
  logic          tick_q;
  logic          start;
  logic          pair;
  logic          shown_q;
  logic [12:0]   val_q [4];
  logic [3:0]    rdy_q;
  logic          four_ch;
  logic          manual;
  logic          wrong_mod;
  logic          cj_eff;
  logic [6:0]    flt_lo;
  logic [6:0]    flt_hi;
  logic [31:0]   res_d;

  temp_cfg_if cfg ();

  // Command pins and the strap come from another domain
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      cmd_meta_q <= 32'h00000000;
      cmd_q      <= 32'h00000000;
      var_meta_q <= 1'b0;
      var_q      <= 1'b0;
    end else begin
      cmd_meta_q <= CMD_I;
      cmd_q      <= cmd_meta_q;
      var_meta_q <= VARIANT_I;
      var_q      <= var_meta_q;
    end
  end

  // 0.1 s tick; every period code counts in these
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == TW'(TICK_CYCLES - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + TW'(1);
      tick_q <= 1'b0;
    end
  end

  // Settings capture
  temp_cfg_latch u_cfg (
    .clk_i (MCLK_I),
    .rst_i (RESET_I),
    .cmd_i (cmd_q),
    .cfg   (cfg)
  );

  // Pair scheduling and manual handshake
  temp_pair_sched u_sched (
    .clk_i      (MCLK_I),
    .rst_i      (RESET_I),
    .tick_i     (tick_q),
    .read_req_i (cmd_q[`CMD_READ_BIT]),
    .pair_sel_i (cmd_q[`CMD_PAIR_BIT]),
    .done_i     (CONV_DONE_I),
    .start_o    (start),
    .pair_o     (pair),
    .cfg        (cfg)
  );

  assign CONV_START_O    = start;
  assign CONV_PAIR_O     = pair;
  assign CONV_CURVE_O    = cfg.curve;
  assign CONV_RES_TYPE_O = cfg.res_type;

  assign four_ch = (cfg.mode != MODE_TWO);
  assign manual  = (cfg.mode == MODE_MANUAL);

  // Pair on display follows the last finished conversion
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      shown_q <= 1'b0;
    end else if (CONV_DONE_I && cfg.valid) begin
      shown_q <= pair;
    end
  end

  // Per-channel value and ready; even index uses the low result
  for (genvar i = 0; i < 4; i++) begin : g_chan
    logic [12:0] raw;
    assign raw = (i % 2 == 0) ? CONV_LO_I : CONV_HI_I;

    always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
        val_q[i] <= 13'h0000;
      end else if (CONV_DONE_I && cfg.valid && pair == 1'((i / 2) % 2)) begin
        // Full 13 bits kept: thermocouple readings above 409.5 need bit 12
        val_q[i] <= raw;
      end
    end

    // A fresh result wins over a dropped request in the same cycle
    always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
        rdy_q[i] <= 1'b0;
      end else if (CONV_DONE_I && cfg.valid && pair == 1'((i / 2) % 2)) begin
        rdy_q[i] <= 1'b1;
      end else if (!cfg.valid || (manual && !cmd_q[`CMD_READ_BIT])) begin
        rdy_q[i] <= 1'b0;
      end
    end
  end

  // Wrong module: configured type disagrees with the strap
  assign wrong_mod = cfg.valid && (cfg.res_type != var_q);
  // Cold-junction sensing exists only on thermocouple parts
  assign cj_eff    = CJ_FLT_I && !cfg.res_type;

  // Fault fields; pair three/four faults only matter with four channels
  assign flt_lo = {wrong_mod, SYS_FLT_I, cj_eff,
                   OPEN_FLT_I[2] & four_ch, RANGE_FLT_I[2] & four_ch,
                   OPEN_FLT_I[0], RANGE_FLT_I[0]};
  assign flt_hi = {wrong_mod, SYS_FLT_I, cj_eff,
                   OPEN_FLT_I[3] & four_ch, RANGE_FLT_I[3] & four_ch,
                   OPEN_FLT_I[1], RANGE_FLT_I[1]};

  // Result word assembly
  always_comb begin
    res_d = 32'h00000000;
    if (flt_lo != 7'h00) begin
      res_d[12:0] = {6'h00, flt_lo};
    end else begin
      res_d[12:0] = shown_q ? val_q[2] : val_q[0];
    end
    res_d[`RES_ABN_LO]    = (flt_lo != 7'h00);
    res_d[`RES_RDY_ONE]   = cfg.valid && rdy_q[0] && !shown_q;
    res_d[`RES_RDY_THREE] = cfg.valid && rdy_q[2] && shown_q;
    if (flt_hi != 7'h00) begin
      res_d[28:16] = {6'h00, flt_hi};
    end else begin
      res_d[28:16] = shown_q ? val_q[3] : val_q[1];
    end
    res_d[`RES_ABN_HI]    = (flt_hi != 7'h00);
    res_d[`RES_RDY_TWO]   = cfg.valid && rdy_q[1] && !shown_q;
    res_d[`RES_RDY_FOUR]  = cfg.valid && rdy_q[3] && shown_q;
  end

  // Registered so the controller never sees a glitch
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      RESULT_O <= 32'h00000000;
    end else begin
      RESULT_O <= res_d;
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  // Ready bits follow a finished conversion two edges later
  sequence s_manual_done_pair0;
    manual && CONV_DONE_I && !pair && cmd_q[`CMD_READ_BIT];
  endsequence

  sequence s_ready_one_shown;
    ##1 cmd_q[`CMD_READ_BIT] ##1 RESULT_O[`RES_RDY_ONE];
  endsequence

  property p_manual_ready;
    s_manual_done_pair0 |-> s_ready_one_shown or ##1 !cmd_q[`CMD_READ_BIT];
  endproperty
  a_manual_ready: assert property (p_manual_ready)
    else $error("manual read not answered with ready");

  property p_unconfigured_quiet;
    !cfg.valid |=> RESULT_O[`RES_RDY_ONE] == 1'b0 && RESULT_O[`RES_RDY_THREE] == 1'b0
                && RESULT_O[`RES_RDY_TWO] == 1'b0 && RESULT_O[`RES_RDY_FOUR] == 1'b0;
  endproperty
  a_unconfigured_quiet: assert property (p_unconfigured_quiet)
    else $error("ready bit seen before configuration");

  property p_ready_exclusive;
    !(RESULT_O[`RES_RDY_ONE] && RESULT_O[`RES_RDY_THREE]);
  endproperty
  a_ready_exclusive: assert property (p_ready_exclusive)
    else $error("channel one and three ready together");

  property p_abn_low;
    !$past(RESET_I) |-> RESULT_O[`RES_ABN_LO] == $past(flt_lo != 7'h00);
  endproperty
  a_abn_low: assert property (p_abn_low)
    else $error("low abnormality flag does not follow faults");

  property p_abn_high_data;
    (!$past(RESET_I) && $past(flt_hi != 7'h00))
      |-> RESULT_O[28:16] == {6'h00, $past(flt_hi)};
  endproperty
  a_abn_high_data: assert property (p_abn_high_data)
    else $error("upper fault field wrong");

  property p_two_ch_pair;
    (cfg.mode == MODE_TWO && start) |-> !pair;
  endproperty
  a_two_ch_pair: assert property (p_two_ch_pair)
    else $error("two-channel mode converted pair three/four");

  property p_manual_select;
    (manual && start) |-> pair == $past(cmd_q[`CMD_PAIR_BIT]);
  endproperty
  a_manual_select: assert property (p_manual_select)
    else $error("manual conversion of wrong pair");

  property p_value_kept;
    (CONV_DONE_I && cfg.valid && !pair) |=> val_q[0] == $past(CONV_LO_I);
  endproperty
  a_value_kept: assert property (p_value_kept)
    else $error("channel one value altered on capture");

  property p_cj_gate;
    (cfg.valid && cfg.res_type) |=> !(RESULT_O[`RES_ABN_LO] && RESULT_O[4]);
  endproperty
  a_cj_gate: assert property (p_cj_gate)
    else $error("cold-junction fault on resistance part");

  property p_low_data;
    (!$past(RESET_I) && !$past(flt_lo != 7'h00) && !$past(shown_q))
      |-> RESULT_O[12:0] == $past(val_q[0]);
  endproperty
  a_low_data: assert property (p_low_data)
    else $error("channel one value not shown");

  // Start is a strobe; a held request must not stretch or repeat it
  property p_one_start;
    start |=> !start;
  endproperty
  a_one_start: assert property (p_one_start)
    else $error("conversion start longer than one cycle");

  property p_pair_held;
    (!start && !$past(RESET_I)) |-> $stable(pair);
  endproperty
  a_pair_held: assert property (p_pair_held)
    else $error("pair changed without a start");

  property p_ready_drop;
    (manual && !cmd_q[`CMD_READ_BIT] && !CONV_DONE_I) |-> ##2
      (RESULT_O & 32'hC000_C000) == 32'h0000_0000;
  endproperty
  a_ready_drop: assert property (p_ready_drop)
    else $error("ready bits kept after request dropped");

  property p_wrong_module;
    (!$past(RESET_I) && $past(cfg.valid && cfg.res_type != var_q))
      |-> RESULT_O[`RES_ABN_LO] && RESULT_O[6];
  endproperty
  a_wrong_module: assert property (p_wrong_module)
    else $error("wrong module not flagged");

  // Internal failure shows in both halves one edge later
  property p_sys_fault;
    (!$past(RESET_I) && $past(SYS_FLT_I))
      |-> RESULT_O[`RES_ABN_LO] && RESULT_O[5] && RESULT_O[`RES_ABN_HI] && RESULT_O[21];
  endproperty
  a_sys_fault: assert property (p_sys_fault)
    else $error("internal failure not flagged");

  // Same answer for a request on channels three and four
  sequence s_manual_done_pair1;
    manual && CONV_DONE_I && pair && cmd_q[`CMD_READ_BIT];
  endsequence

  sequence s_ready_three_shown;
    ##1 cmd_q[`CMD_READ_BIT] ##1 RESULT_O[`RES_RDY_THREE] && RESULT_O[`RES_RDY_FOUR];
  endsequence

  property p_manual_ready_pair1;
    s_manual_done_pair1 |-> s_ready_three_shown or ##1 !cmd_q[`CMD_READ_BIT];
  endproperty
  a_manual_ready_pair1: assert property (p_manual_ready_pair1)
    else $error("manual read of pair three/four not answered");

  // A double tick would halve every period
  property p_tick_single;
    tick_q |=> !tick_q;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("divider ticked twice in a row");
endmodule : temp_host_word
`default_nettype wire

// file: hw/temp_consts.svh
`ifndef TEMP_CONSTS_SVH
`define TEMP_CONSTS_SVH
// Command word bit positions
`define CMD_PERIOD_MSB 15
`define CMD_COMMIT_BIT 16
`define CMD_TYPE_BIT   17
`define CMD_CURVE_BIT  18
`define CMD_READ_BIT   22
`define CMD_FOUR_BIT   24
`define CMD_MANUAL_BIT 25
`define CMD_PAIR_BIT   26
// Result word bit positions
`define RES_ABN_LO     13
`define RES_RDY_ONE    14
`define RES_RDY_THREE  15
`define RES_ABN_HI     29
`define RES_RDY_TWO    30
`define RES_RDY_FOUR   31
// Period codes, in tenths of a second
`define PERIOD_MIN     16'h0005
`define PERIOD_MAX     16'h0064
`define PERIOD_DEF     16'h0028
// Timing: base tick and two-channel refresh
`define CLK_KHZ        50000
`define TICK_MS        100
`define TWO_CH_MS      300
`define TWO_CH_TICKS   (`TWO_CH_MS / `TICK_MS)
`endif

// file: hw/temp_pkg.sv
`default_nettype none
package temp_pkg;
  // Measurement modes chosen at configuration time
  typedef enum logic [1:0] {MODE_TWO, MODE_AUTO, MODE_MANUAL} meas_mode_t;
  // Conversion scheduler states
  typedef enum logic [1:0] {SCH_IDLE, SCH_WAIT, SCH_CONV} sched_state_t;
endpackage : temp_pkg
`default_nettype wire

// file: hw/temp_cfg_if.sv
`default_nettype none
interface temp_cfg_if;
  import temp_pkg::*;
  logic        valid;
  meas_mode_t  mode;
  logic [15:0] period;
  logic        res_type;
  logic        curve;
  // Latch drives the settings, everyone else only reads
  modport src (output valid, output mode, output period, output res_type, output curve);
  modport dst (input valid, input mode, input period, input res_type, input curve);
endinterface : temp_cfg_if
`default_nettype wire

// file: hw/temp_cfg_latch.sv
`include "temp_consts.svh"
`default_nettype none
module temp_cfg_latch
  import temp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Synchronised command word
  input  wire logic [31:0] cmd_i,
  // Frozen settings
  temp_cfg_if.src          cfg
);
  logic [15:0] code;
  logic        code_ok;

  // Out-of-range codes, including an absent zero, fall back to four seconds
  assign code    = cmd_i[`CMD_PERIOD_MSB:0];
  assign code_ok = (code >= `PERIOD_MIN) && (code <= `PERIOD_MAX);

  // One capture per reset; later commits are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg.valid    <= 1'b0;
      cfg.mode     <= MODE_TWO;
      cfg.period   <= `PERIOD_DEF;
      cfg.res_type <= 1'b0;
      cfg.curve    <= 1'b0;
    end else if (!cfg.valid && cmd_i[`CMD_COMMIT_BIT]) begin
      cfg.valid    <= 1'b1;
      cfg.period   <= code_ok ? code : `PERIOD_DEF;
      cfg.res_type <= cmd_i[`CMD_TYPE_BIT];
      cfg.curve    <= cmd_i[`CMD_CURVE_BIT];
      if (!cmd_i[`CMD_FOUR_BIT]) begin
        cfg.mode <= MODE_TWO;
      end else if (cmd_i[`CMD_MANUAL_BIT]) begin
        cfg.mode <= MODE_MANUAL;
      end else begin
        cfg.mode <= MODE_AUTO;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_period_legal;
    cfg.valid |-> (cfg.period >= `PERIOD_MIN) && (cfg.period <= `PERIOD_MAX);
  endproperty
  a_period_legal: assert property (p_period_legal)
    else $error("period outside legal codes");

  property p_frozen;
    cfg.valid |=> cfg.valid && $stable(cfg.mode) && $stable(cfg.period) && $stable(cfg.curve);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("settings changed after capture");
endmodule : temp_cfg_latch
`default_nettype wire

// file: hw/temp_pair_sched.sv
`include "temp_consts.svh"
`default_nettype none
module temp_pair_sched
  import temp_pkg::*;
(
  // Clock, reset and 0.1 s tick
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  // Manual handshake levels, already synchronised
  input  wire logic read_req_i,
  input  wire logic pair_sel_i,
  // Converter
  input  wire logic done_i,
  output logic      start_o,
  output logic      pair_o,
  // Settings
  temp_cfg_if.dst   cfg
);
  sched_state_t state_q;
  logic [15:0]  tick_cnt_q;
  logic [15:0]  interval;
  logic         served_q;
  logic         next_pair_q;

  // Two-channel runs at a fixed 0.3 s, automatic at the programmed code
  assign interval = (cfg.mode == MODE_TWO) ? 16'(`TWO_CH_TICKS) : cfg.period;

  // Conversion sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= SCH_IDLE;
      tick_cnt_q  <= 16'h0000;
      start_o     <= 1'b0;
      pair_o      <= 1'b0;
      next_pair_q <= 1'b0;
    end else begin
      start_o <= 1'b0;
      case (state_q)
        SCH_IDLE: begin
          if (cfg.valid) begin
            state_q <= SCH_WAIT;
          end
        end
        SCH_WAIT: begin
          if (cfg.mode == MODE_MANUAL) begin
            if (read_req_i && !served_q) begin
              start_o <= 1'b1;
              pair_o  <= pair_sel_i;
              state_q <= SCH_CONV;
            end
          end else if (tick_i) begin
            if (tick_cnt_q >= interval - 16'h0001) begin
              tick_cnt_q  <= 16'h0000;
              start_o     <= 1'b1;
              pair_o      <= (cfg.mode == MODE_TWO) ? 1'b0 : next_pair_q;
              next_pair_q <= ~next_pair_q;
              state_q     <= SCH_CONV;
            end else begin
              tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
          end
        end
        SCH_CONV: begin
          if (done_i) begin
            state_q <= SCH_WAIT;
          end
        end
        default: state_q <= SCH_IDLE;
      endcase
    end
  end

  // One conversion per raised request; the request must drop before the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      served_q <= 1'b0;
    end else if (start_o && cfg.mode == MODE_MANUAL) begin
      served_q <= 1'b1;
    end else if (!read_req_i) begin
      served_q <= 1'b0;
    end
  end
endmodule : temp_pair_sched
`default_nettype wire

// file: bench/temp_conv_model.sv
`default_nettype none
module temp_conv_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Conversion request
  input  wire logic        start_i,
  // Answer shape set by the bench
  input  wire logic [4:0]  lat_i,
  input  wire logic [12:0] lo_val_i,
  input  wire logic [12:0] hi_val_i,
  // Conversion answer
  output logic             done_o,
  output logic [12:0]      lo_o,
  output logic [12:0]      hi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] cnt_q;

  // One done pulse per start, lat_i cycles later (lat_i must be nonzero)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 5'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_q == 5'h01);
      if (start_i) begin
        cnt_q <= lat_i;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  // Data holds only with done; stale values inverted so they never pass
  assign lo_o = done_o ? lo_val_i : ~lo_val_i;
  assign hi_o = done_o ? hi_val_i : ~hi_val_i;
endmodule : temp_conv_model
`default_nettype wire

// file: bench/temp_host_word_tb_top.sv
`include "temp_consts.svh"
`default_nettype none
module temp_host_word_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;

  typedef struct {
    logic [31:0] cmd;
    logic        var_s;
    logic        pair;
    logic [12:0] lo;
    logic [12:0] hi;
    logic [4:0]  lat;
  } row_t;

  // Bit 19 always left clear in every command
  row_t rows [4] = '{
    '{32'h0000_0000, 1'b0, 1'b0, 13'h03ED, 13'h01F3, 5'h03},
    '{32'h0106_0005, 1'b1, 1'b0, 13'h1F9C, 13'h1FFB, 5'h08},
    '{32'h0704_0000, 1'b0, 1'b1, 13'h1770, 13'h0000, 5'h01},
    '{32'h0302_0000, 1'b1, 1'b0, 13'h0000, 13'h0BB8, 5'h0C}};
  int codes [5] = '{0, 4, 5, 100, 101};
  int ticks [5] = '{40, 40, 5, 100, 40};
  int fbit [4] = '{0, 1, 4, 5};

  // Bench drives
  logic        clk, rst, variant, cj_flt, sys_flt;
  logic [31:0] cmd;
  logic [3:0]  range_flt, open_flt;
  logic [4:0]  lat;
  logic [12:0] lo_val, hi_val;
  // Design and converter answers
  logic        done, start, pair, curve, res_type;
  logic [12:0] conv_lo, conv_hi;
  logic [31:0] result;
  int          errors, tests_run, n;

  temp_host_word #(.TICK_CYCLES(TICK)) i_temp_host_word (
    .MCLK_I(clk), .RESET_I(rst), .CMD_I(cmd), .VARIANT_I(variant),
    .CONV_DONE_I(done), .CONV_LO_I(conv_lo), .CONV_HI_I(conv_hi),
    .RANGE_FLT_I(range_flt), .OPEN_FLT_I(open_flt), .CJ_FLT_I(cj_flt),
    .SYS_FLT_I(sys_flt), .CONV_START_O(start), .CONV_PAIR_O(pair),
    .CONV_CURVE_O(curve), .CONV_RES_TYPE_O(res_type), .RESULT_O(result));

  temp_conv_model i_temp_conv_model (
    .clk_i(clk), .rst_i(rst), .start_i(start), .lat_i(lat), .lo_val_i(lo_val),
    .hi_val_i(hi_val), .done_o(done), .lo_o(conv_lo), .hi_o(conv_hi));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop;
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk

  task automatic cycles(input int len);
    repeat (len) @(negedge clk);
  endtask : cycles

  // Bounded wait for the next start pulse; n is the cycles waited
  task automatic wait_start(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (k > 2000) begin
        $display("[ERR] start expected 1 seen %b", start);
        errors++;
        report_and_stop();
      end
    end while (start !== 1'b1);
  endtask : wait_start

  task automatic count_starts(input int len, output int k);
    k = 0;
    repeat (len) begin
      @(negedge clk);
      if (start === 1'b1) k++;
    end
  endtask : count_starts

  // Reset, settings held stable, then optional commit
  task automatic setup_cfg(input logic [31:0] c, input logic v, input logic go);
    @(posedge clk);
    rst     <= 1'b1;
    cmd     <= c;
    variant <= v;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    cmd[`CMD_COMMIT_BIT] <= go;
    @(negedge clk);
  endtask : setup_cfg

  function automatic logic [31:0] exp_word(input logic p, input logic [12:0] lo,
                                           input logic [12:0] hi);
    logic [31:0] w;
    w = {3'b000, hi, 3'b000, lo};
    w[`RES_RDY_ONE]   = ~p;
    w[`RES_RDY_THREE] = p;
    w[`RES_RDY_TWO]   = ~p;
    w[`RES_RDY_FOUR]  = p;
    return w;
  endfunction : exp_word

  initial begin
    rst = 1'b1;
    cmd = 32'h0;
    variant = 1'b0;
    range_flt = 4'h0;
    open_flt = 4'h0;
    cj_flt = 1'b0;
    sys_flt = 1'b0;
    lat = 5'h02;
    lo_val = 13'h0000;
    hi_val = 13'h0000;
    errors = 0;
    tests_run = 0;
    // Ordinary cases: every mode and both variants; manual once per variant
    foreach (rows[i]) begin
      @(posedge clk);
      lat    <= rows[i].lat;
      lo_val <= rows[i].lo;
      hi_val <= rows[i].hi;
      setup_cfg(rows[i].cmd, rows[i].var_s, 1'b1);
      if (rows[i].cmd[`CMD_MANUAL_BIT]) begin
        cycles(20);
        @(posedge clk);
        cmd[`CMD_READ_BIT] <= 1'b1;
      end
      wait_start(n);
      chk("pair", 32'(rows[i].pair), 32'(pair));
      cycles(rows[i].lat + 6);
      chk("result", exp_word(rows[i].pair, rows[i].lo, rows[i].hi), result);
      chk("type", 32'(rows[i].cmd[`CMD_TYPE_BIT]), 32'(res_type));
      chk("curve", 32'(rows[i].cmd[`CMD_CURVE_BIT]), 32'(curve));
    end
    // Period codes, in range and out of it; code 0 means none given
    foreach (codes[i]) begin
      setup_cfg({16'h0100, 16'(codes[i])}, 1'b0, 1'b1);
      wait_start(n);
      wait_start(n);
      chk("gap", 32'h1, 32'((n >= ticks[i] * TICK - TICK) && (n <= ticks[i] * TICK + 2 * TICK)));
      chk("alt_pair", 32'h1, 32'(pair));
    end
    // Nothing runs before commit; later commits change nothing
    setup_cfg(32'h0100_0005, 1'b0, 1'b0);
    count_starts(100, n);
    chk("starts_unconfigured", 32'h0, 32'(n));
    chk("ready_unconfigured", 32'h0, result & 32'hC000_C000);
    @(posedge clk);
    cmd[`CMD_COMMIT_BIT] <= 1'b1;
    wait_start(n);
    chk("late_commit", 32'h1, 32'(n <= 80));
    @(posedge clk);
    cmd <= 32'h0106_0064;
    cycles(4);
    @(posedge clk);
    cmd[`CMD_COMMIT_BIT] <= 1'b1;
    wait_start(n);
    wait_start(n);
    chk("period_frozen", 32'h1, 32'(n <= 80));
    chk("curve_frozen", 32'h0, 32'(curve));
    chk("type_frozen", 32'h0, 32'(res_type));
    // Held request gives one conversion; drop clears ready
    setup_cfg(32'h0300_0000, 1'b0, 1'b1);
    cycles(20);
    @(posedge clk);
    cmd[`CMD_READ_BIT] <= 1'b1;
    wait_start(n);
    count_starts(100, n);
    chk("one_per_request", 32'h0, 32'(n));
    chk("ready_held", 32'h4000_4000, result & 32'hC000_C000);
    @(posedge clk);
    cmd[`CMD_READ_BIT] <= 1'b0;
    cycles(6);
    chk("ready_cleared", 32'h0, result & 32'hC000_C000);
    @(posedge clk);
    cmd[`CMD_PAIR_BIT] <= 1'b1;
    cmd[`CMD_READ_BIT] <= 1'b1;
    wait_start(n);
    chk("manual_pair", 32'h1, 32'(pair));
    cycles(lat + 6);
    chk("ready_pair1", 32'h8000_8000, result & 32'hC000_C000);
    // Channel three range and channel four open faults in four-channel mode
    @(posedge clk);
    range_flt <= 4'h4;
    open_flt  <= 4'h8;
    cycles(3);
    chk("pair1_faults", 32'h2008_2004, result & 32'h207F_207F);
    @(posedge clk);
    range_flt <= 4'h0;
    open_flt  <= 4'h0;
    // Each fault kind on its own flag
    setup_cfg(32'h0000_0000, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      range_flt <= {2'b00, k == 0, k == 0};
      open_flt  <= {2'b00, k == 1, k == 1};
      cj_flt    <= (k == 2);
      sys_flt   <= (k == 3);
      cycles(5);
      n = 32'h0001_0001 << fbit[k];
      chk("fault", 32'h2000_2000 | n, result & 32'h207F_207F);
    end
    @(posedge clk);
    sys_flt <= 1'b0;
    cycles(5);
    chk("abn_clear", 32'h0, 32'(result[`RES_ABN_LO]));
    // Commanded type differs from the installed strap
    setup_cfg(32'h0002_0000, 1'b0, 1'b1);
    cycles(6);
    chk("wrong_module", 32'h0000_2040, result & 32'h0000_207F);
    report_and_stop();
  end
endmodule : temp_host_word_tb_top
`default_nettype wire
